// file: bat_match.sv
// attribute trigger registers, bus attribute match and attribute decode
// Notes on behaviour
// [R1] each trigger register is compared with bus attributes; use gated by definitions
// [R2] direction mask bit 15 removes the direction bit from the compare
// [R3] size mask bits 14-13 remove matching expected size bits
// [R4] transfer type mask bits 12-11 remove matching expected type bits
// [R5] modifier mask bits 10-8 remove matching expected modifier bits
// [R6] expected direction bit 7 compared with bus read/write on every transfer
// [R7] expected size bits 6-5 compared with bus size: long, byte, word, reserved
// [R8] expected type bits 4-3: normal, reserved, emulator, acknowledge/cpu space
// [R9] type code also selects debug memory command space; 01 means external/dma
// [R10] expected modifier bits 2-0 compared; meaning depends on transfer type
// [R11] normal mode modifiers: push, user data/code, invalidate, push, supervisor, touch
// [R12] emulator mode: modifier 101 is emulator data, others reserved
// [R13] acknowledge mode: 000 cpu space, 001-111 interrupt acknowledge levels 1-7
// [R14] modifier encoding also applies to debug memory commands
// [R15] match only when every unmasked field equals the current transfer
// [R16] both trigger registers reset to 0x0000_0005, reachable by host and software
`timescale 1ns/100ps

module bat_match
  import bat_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic dbg_wr,
  input wire logic dbg_rd,
  input wire logic [4:0] dbg_idx,
  input wire logic [31:0] dbg_wdata,
  output logic [31:0] dbg_rdata,
  output logic dbg_rd_valid,
  input wire logic trig_def_use,
  input wire logic ext_trig_def_use,
  input wire logic bus_xfer_valid,
  input wire logic bus_read,
  input wire logic [1:0] bus_size,
  input wire logic [1:0] bus_xfer_type,
  input wire logic [2:0] bus_xfer_mod,
  input wire logic bdm_mem_cmd,
  input wire logic [1:0] bdm_xfer_type,
  input wire logic [2:0] bdm_xfer_mod,
  output logic attr_hit_0,
  output logic attr_hit_1,
  output bat_class_t bus_class,
  output logic [2:0] bus_int_level,
  output logic bus_size_rsvd,
  output bat_class_t bdm_class,
  output logic bdm_ext_dma
);

  // turn a type/modifier pair into its meaning; debug commands see 01 as external
  function automatic bat_class_t bat_decode(
    input logic [1:0] xtype,
    input logic [2:0] xmod,
    input logic for_bdm
  );
    bat_class_t cls;
    cls = BAT_CLS_RESERVED;
    unique case (xtype)
      BAT_TT_NORMAL: begin // R11
        unique case (xmod)
          BAT_TM_LINE_PUSH: cls = BAT_CLS_LINE_PUSH;
          BAT_TM_USER_DATA: cls = BAT_CLS_USER_DATA;
          BAT_TM_USER_CODE: cls = BAT_CLS_USER_CODE;
          BAT_TM_ICACHE_INV: cls = BAT_CLS_ICACHE_INV;
          BAT_TM_DCACHE_PUSH: cls = BAT_CLS_DCACHE_PUSH;
          BAT_TM_SUP_DATA: cls = BAT_CLS_SUP_DATA;
          BAT_TM_TOUCH: cls = BAT_CLS_TOUCH;
          default: cls = BAT_CLS_RESERVED;
        endcase
      end
      BAT_TT_EXT: begin
        // only a debug memory command gives this code a meaning
        cls = for_bdm ? BAT_CLS_EXT_DMA : BAT_CLS_RESERVED; // R9
      end
      BAT_TT_EMU: begin
        if (xmod == BAT_TM_EMU_DATA) begin // R12
          cls = BAT_CLS_EMU_DATA;
        end else begin
          cls = BAT_CLS_RESERVED;
        end
      end
      BAT_TT_ACK: begin
        if (xmod == BAT_TM_CPU_SPACE) begin // R13
          cls = BAT_CLS_CPU_SPACE;
        end else begin
          cls = BAT_CLS_INT_ACK;
        end
      end
    endcase
    return cls;
  endfunction

  // ---- register file ----
  logic [15:0] trig_reg [2];
  logic [15:0] trig_next [2];
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [4:0] trig_idx [2];

  assign trig_idx[0] = BAT_IDX_TRIG0;
  assign trig_idx[1] = BAT_IDX_TRIG1;

  // a write to the matching index replaces the whole 16-bit register
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      trig_next[i] = trig_reg[i];
      if (dbg_wr && dbg_idx == trig_idx[i]) begin // R16
        trig_next[i] = dbg_wdata[15:0];
      end
    end
  end

  // reads return the register in the low half; other indexes read zero
  always_comb begin
    rdata_next = rdata_reg;
    rd_valid_next = 1'b0;
    if (dbg_rd) begin
      rd_valid_next = 1'b1;
      if (dbg_idx == BAT_IDX_TRIG0) begin
        rdata_next = {16'h0000, trig_reg[0]};
      end else if (dbg_idx == BAT_IDX_TRIG1) begin
        rdata_next = {16'h0000, trig_reg[1]};
      end else begin
        rdata_next = BAT_RD_ZERO;
      end
    end
  end

  // both registers come up as normal supervisor data, write direction and long size, nothing masked
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_reg[0] <= BAT_TRIG_RESET; // R16
      trig_reg[1] <= BAT_TRIG_RESET; // R16
      rdata_reg <= BAT_RD_ZERO;
      rd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      trig_reg[0] <= trig_next[0];
      trig_reg[1] <= trig_next[1];
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign dbg_rdata = rdata_reg;
  assign dbg_rd_valid = rd_valid_reg;

  // ---- attribute compare, one comparator per trigger register ----
  logic [1:0] cmp_hit;
  logic [1:0] use_en;
  logic [1:0] hit_reg;
  logic [1:0] hit_next;

  assign use_en = {ext_trig_def_use, trig_def_use};

  for (genvar g = 0; g < 2; g++) begin : g_cmp
    bat_attr_cmp u_cmp (
      .trig(trig_reg[g]),
      .bus_read(bus_read),
      .bus_size(bus_size),
      .bus_xfer_type(bus_xfer_type),
      .bus_xfer_mod(bus_xfer_mod),
      .hit(cmp_hit[g])
    );
  end

  // a hit needs a live transfer and the owning definition selecting it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      hit_next[i] = bus_xfer_valid & use_en[i] & cmp_hit[i]; // R1 R15
    end
  end

  // registered so the trigger sequencer sees a clean one-cycle result
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_reg <= 2'h0;
    end else if (clk_en) begin
      hit_reg <= hit_next;
    end
  end

  assign attr_hit_0 = hit_reg[0];
  assign attr_hit_1 = hit_reg[1];

  // ---- bus attribute decode ----
  bat_class_t bus_class_reg;
  bat_class_t bus_class_next;
  logic [2:0] int_level_reg;
  logic [2:0] int_level_next;
  logic size_rsvd_reg;
  logic size_rsvd_next;

  // decode held between transfers so observers see the last one
  always_comb begin
    bus_class_next = bus_class_reg;
    int_level_next = int_level_reg;
    size_rsvd_next = size_rsvd_reg;
    if (bus_xfer_valid) begin
      bus_class_next = bat_decode(bus_xfer_type, bus_xfer_mod, 1'b0); // R10
      // interrupt level is the modifier itself, zero for other classes
      if (bus_xfer_type == BAT_TT_ACK && bus_xfer_mod != BAT_TM_CPU_SPACE) begin
        int_level_next = bus_xfer_mod; // R13
      end else begin
        int_level_next = 3'h0;
      end
      size_rsvd_next = (bus_size == BAT_SZ_RSVD); // R7
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_class_reg <= BAT_CLS_LINE_PUSH;
      int_level_reg <= 3'h0;
      size_rsvd_reg <= 1'b0;
    end else if (clk_en) begin
      bus_class_reg <= bus_class_next;
      int_level_reg <= int_level_next;
      size_rsvd_reg <= size_rsvd_next;
    end
  end

  assign bus_class = bus_class_reg;
  assign bus_int_level = int_level_reg;
  assign bus_size_rsvd = size_rsvd_reg;

  // ---- debug memory command address space decode ----
  bat_class_t bdm_class_reg;
  bat_class_t bdm_class_next;
  logic bdm_ext_reg;
  logic bdm_ext_next;

  // same encodings serve the debug memory commands, with 01 as external
  always_comb begin
    bdm_class_next = bdm_class_reg;
    bdm_ext_next = bdm_ext_reg;
    if (bdm_mem_cmd) begin
      bdm_class_next = bat_decode(bdm_xfer_type, bdm_xfer_mod, 1'b1); // R9 R14
      bdm_ext_next = (bdm_xfer_type == BAT_TT_EXT); // R9
    end
  end

  // reset default is supervisor data, matching the reset attribute value
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bdm_class_reg <= BAT_CLS_SUP_DATA;
      bdm_ext_reg <= 1'b0;
    end else if (clk_en) begin
      bdm_class_reg <= bdm_class_next;
      bdm_ext_reg <= bdm_ext_next;
    end
  end

  assign bdm_class = bdm_class_reg;
  assign bdm_ext_dma = bdm_ext_reg;

endmodule

// file: bat_cmp.sv
// shared constants and the per-register attribute comparator
`timescale 1ns/100ps

package bat_pkg;
  // register index carried by the debug register commands
  localparam int BAT_IDX_W = 5;
  localparam logic [4:0] BAT_IDX_TRIG0 = 5'h06;
  localparam logic [4:0] BAT_IDX_TRIG1 = 5'h16;
  localparam int BAT_DATA_W = 32;
  localparam int BAT_REG_W = 16;
  localparam logic [15:0] BAT_TRIG_RESET = 16'h0005;
  localparam logic [31:0] BAT_RD_ZERO = 32'h0000_0000;
  // field positions inside an attribute trigger register
  localparam int BAT_DIR_MASK_BIT = 15;
  localparam int BAT_SZM_HI = 14;
  localparam int BAT_SZM_LO = 13;
  localparam int BAT_TTM_HI = 12;
  localparam int BAT_TTM_LO = 11;
  localparam int BAT_TMM_HI = 10;
  localparam int BAT_TMM_LO = 8;
  localparam int BAT_DIR_BIT = 7;
  localparam int BAT_SZ_HI = 6;
  localparam int BAT_SZ_LO = 5;
  localparam int BAT_TT_HI = 4;
  localparam int BAT_TT_LO = 3;
  localparam int BAT_TM_HI = 2;
  localparam int BAT_TM_LO = 0;
  // size encodings
  localparam logic [1:0] BAT_SZ_LONG = 2'h0;
  localparam logic [1:0] BAT_SZ_BYTE = 2'h1;
  localparam logic [1:0] BAT_SZ_WORD = 2'h2;
  localparam logic [1:0] BAT_SZ_RSVD = 2'h3;
  // transfer type encodings
  localparam logic [1:0] BAT_TT_NORMAL = 2'h0;
  localparam logic [1:0] BAT_TT_EXT = 2'h1;
  localparam logic [1:0] BAT_TT_EMU = 2'h2;
  localparam logic [1:0] BAT_TT_ACK = 2'h3;
  // transfer modifier encodings
  localparam logic [2:0] BAT_TM_LINE_PUSH = 3'h0;
  localparam logic [2:0] BAT_TM_USER_DATA = 3'h1;
  localparam logic [2:0] BAT_TM_USER_CODE = 3'h2;
  localparam logic [2:0] BAT_TM_ICACHE_INV = 3'h3;
  localparam logic [2:0] BAT_TM_DCACHE_PUSH = 3'h4;
  localparam logic [2:0] BAT_TM_SUP_DATA = 3'h5;
  localparam logic [2:0] BAT_TM_TOUCH = 3'h7;
  localparam logic [2:0] BAT_TM_EMU_DATA = 3'h5;
  localparam logic [2:0] BAT_TM_CPU_SPACE = 3'h0;
  // decoded meaning of a type/modifier pair
  typedef enum logic [3:0] {
    BAT_CLS_LINE_PUSH = 4'h0,
    BAT_CLS_USER_DATA = 4'h1,
    BAT_CLS_USER_CODE = 4'h2,
    BAT_CLS_ICACHE_INV = 4'h3,
    BAT_CLS_DCACHE_PUSH = 4'h4,
    BAT_CLS_SUP_DATA = 4'h5,
    BAT_CLS_TOUCH = 4'h6,
    BAT_CLS_EMU_DATA = 4'h7,
    BAT_CLS_CPU_SPACE = 4'h8,
    BAT_CLS_INT_ACK = 4'h9,
    BAT_CLS_EXT_DMA = 4'ha,
    BAT_CLS_RESERVED = 4'hf
  } bat_class_t;
endpackage

module bat_attr_cmp
  import bat_pkg::*;
(
  input wire logic [15:0] trig,
  input wire logic bus_read,
  input wire logic [1:0] bus_size,
  input wire logic [1:0] bus_xfer_type,
  input wire logic [2:0] bus_xfer_mod,
  output logic hit
);
  logic dir_diff;
  logic [1:0] size_diff;
  logic [1:0] type_diff;
  logic [2:0] mod_diff;

  // per-field mismatch with masked bits forced to agree
  always_comb begin
    dir_diff = (trig[BAT_DIR_BIT] ^ bus_read) & ~trig[BAT_DIR_MASK_BIT]; // R2 R6
    size_diff = (trig[BAT_SZ_HI:BAT_SZ_LO] ^ bus_size)
      & ~trig[BAT_SZM_HI:BAT_SZM_LO]; // R3 R7
    type_diff = (trig[BAT_TT_HI:BAT_TT_LO] ^ bus_xfer_type)
      & ~trig[BAT_TTM_HI:BAT_TTM_LO]; // R4 R8
    mod_diff = (trig[BAT_TM_HI:BAT_TM_LO] ^ bus_xfer_mod)
      & ~trig[BAT_TMM_HI:BAT_TMM_LO]; // R5 R10
    // all unmasked fields must agree
    hit = ~(dir_diff | (|size_diff) | (|type_diff) | (|mod_diff)); // R15
  end
endmodule

// file: bat_match_properties.sv
// checker for the attribute trigger match block
`timescale 1ns/100ps
module bat_match_chk
  import bat_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic dbg_wr,
  input wire logic dbg_rd,
  input wire logic [4:0] dbg_idx,
  input wire logic [31:0] dbg_wdata,
  input wire logic [31:0] dbg_rdata,
  input wire logic dbg_rd_valid,
  input wire logic trig_def_use,
  input wire logic ext_trig_def_use,
  input wire logic bus_xfer_valid,
  input wire logic bus_read,
  input wire logic [1:0] bus_size,
  input wire logic [1:0] bus_xfer_type,
  input wire logic [2:0] bus_xfer_mod,
  input wire logic bdm_mem_cmd,
  input wire logic [1:0] bdm_xfer_type,
  input wire logic attr_hit_0,
  input wire logic attr_hit_1,
  input wire bat_class_t bus_class,
  input wire logic [2:0] bus_int_level,
  input wire logic bus_size_rsvd,
  input wire logic bdm_ext_dma
);
  logic [15:0] sh0_reg;
  logic [15:0] sh1_reg;
  logic [7:0] bus_attr;
  logic exp0;
  logic exp1;
  logic [31:0] rd_exp;
  // shadow copies of the trigger registers, kept from the write strobes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh0_reg <= BAT_TRIG_RESET;
      sh1_reg <= BAT_TRIG_RESET;
    end else if (clk_en && dbg_wr) begin
      if (dbg_idx == BAT_IDX_TRIG0) sh0_reg <= dbg_wdata[15:0];
      if (dbg_idx == BAT_IDX_TRIG1) sh1_reg <= dbg_wdata[15:0];
    end
  end
  // mask byte lines up bit for bit with the expected attribute byte
  assign bus_attr = {bus_read, bus_size, bus_xfer_type, bus_xfer_mod};
  assign exp0 = bus_xfer_valid && trig_def_use
    && ~|((sh0_reg[7:0] ^ bus_attr) & ~sh0_reg[15:8]);
  assign exp1 = bus_xfer_valid && ext_trig_def_use
    && ~|((sh1_reg[7:0] ^ bus_attr) & ~sh1_reg[15:8]);
  assign rd_exp = (dbg_idx == BAT_IDX_TRIG0) ? {16'h0000, sh0_reg}
    : (dbg_idx == BAT_IDX_TRIG1) ? {16'h0000, sh1_reg} : BAT_RD_ZERO;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  chk_hit0_value: assert property (clk_en |=> attr_hit_0 == $past(exp0))
    else $error("attribute hit 0 wrong");
  chk_hit1_value: assert property (clk_en |=> attr_hit_1 == $past(exp1))
    else $error("attribute hit 1 wrong");
  chk_use_gate: assert property (clk_en && !ext_trig_def_use |=> !attr_hit_1)
    else $error("hit 1 without use enable");
  chk_read_pulse: assert property (clk_en && dbg_rd |=> dbg_rd_valid)
    else $error("read valid missing");
  chk_read_data: assert property (clk_en && dbg_rd |=> dbg_rdata == $past(rd_exp))
    else $error("read data wrong");
  chk_int_level: assert property (clk_en && bus_xfer_valid && bus_xfer_type == BAT_TT_ACK
    |=> bus_int_level == $past(bus_xfer_mod)) else $error("interrupt level wrong");
  chk_size_rsvd: assert property (clk_en && bus_xfer_valid
    |=> bus_size_rsvd == ($past(bus_size) == BAT_SZ_RSVD)) else $error("size flag wrong");
  chk_bdm_ext: assert property (clk_en && bdm_mem_cmd
    |=> bdm_ext_dma == ($past(bdm_xfer_type) == BAT_TT_EXT)) else $error("dma flag wrong");
  chk_touch_class: assert property (clk_en && bus_xfer_valid && bus_attr[4:0] == 5'h07
    |=> bus_class == BAT_CLS_TOUCH) else $error("touch decode wrong");
  cover property (attr_hit_0 && attr_hit_1);
  cover property (bus_xfer_valid && !attr_hit_1 ##1 attr_hit_0);
  cover property (dbg_rd_valid);
endmodule

bind bat_match bat_match_chk u_chk (.core_clk, .rst_b, .clk_en, .dbg_wr, .dbg_rd, .dbg_idx,
  .dbg_wdata, .dbg_rdata, .dbg_rd_valid, .trig_def_use, .ext_trig_def_use, .bus_xfer_valid,
  .bus_read, .bus_size, .bus_xfer_type, .bus_xfer_mod, .bdm_mem_cmd, .bdm_xfer_type,
  .attr_hit_0, .attr_hit_1, .bus_class, .bus_int_level, .bus_size_rsvd, .bdm_ext_dma);

// file: bat_bus_model.sv
// local bus model presenting one attribute set per cycle
`timescale 1ns/100ps
module bat_bus_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] attr,
  output logic bus_xfer_valid,
  output logic bus_read,
  output logic [1:0] bus_size,
  output logic [1:0] bus_xfer_type,
  output logic [2:0] bus_xfer_mod
);
  logic [7:0] last_reg = 8'h00;
  // idle cycles show inverted attributes so stale values never match by luck
  always @(posedge core_clk) begin
    if (go) begin
      last_reg <= attr;
    end
  end
  assign bus_xfer_valid = go;
  assign {bus_read, bus_size, bus_xfer_type, bus_xfer_mod} = go ? attr : ~last_reg;
endmodule

// file: testbench.sv
// self-checking bench for the attribute trigger match block
`timescale 1ns/100ps
module testbench;
  import bat_pkg::*;
  logic core_clk;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic dbg_wr = 1'b0;
  logic dbg_rd = 1'b0;
  logic [4:0] dbg_idx = 5'h00;
  logic [31:0] dbg_wdata = 32'h0000_0000;
  logic [31:0] dbg_rdata;
  logic dbg_rd_valid;
  logic use0 = 1'b1;
  logic use1 = 1'b1;
  logic go = 1'b0;
  logic [7:0] attr = 8'h00;
  logic bdm_cmd = 1'b0;
  logic bus_xfer_valid, bus_read, attr_hit_0, attr_hit_1, bus_size_rsvd, bdm_ext_dma;
  logic [1:0] bus_size, bus_xfer_type;
  logic [2:0] bus_xfer_mod, bus_int_level;
  bat_class_t bus_class, bdm_class;
  int miscompares = 0;
  int n_checks = 0;
  // trigger value, bus attributes, expected hit
  logic [15:0] tv [12] = '{16'h0005, 16'h0005, 16'h8005, 16'h0025, 16'h2025, 16'h001d,
    16'h181d, 16'h0007, 16'h0207, 16'h0015, 16'h0045, 16'h0005};
  logic [7:0] av [12] = '{8'h05, 8'h85, 8'h85, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05,
    8'h15, 8'h45, 8'h65};
  logic ev [12] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  bat_bus_model u_bus (.core_clk(core_clk), .go(go), .attr(attr),
    .bus_xfer_valid(bus_xfer_valid), .bus_read(bus_read), .bus_size(bus_size),
    .bus_xfer_type(bus_xfer_type), .bus_xfer_mod(bus_xfer_mod));
  bat_match DUT (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .dbg_wr(dbg_wr),
    .dbg_rd(dbg_rd), .dbg_idx(dbg_idx), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata),
    .dbg_rd_valid(dbg_rd_valid), .trig_def_use(use0), .ext_trig_def_use(use1),
    .bus_xfer_valid(bus_xfer_valid), .bus_read(bus_read), .bus_size(bus_size),
    .bus_xfer_type(bus_xfer_type), .bus_xfer_mod(bus_xfer_mod), .bdm_mem_cmd(bdm_cmd),
    .bdm_xfer_type(attr[4:3]), .bdm_xfer_mod(attr[2:0]), .attr_hit_0(attr_hit_0),
    .attr_hit_1(attr_hit_1), .bus_class(bus_class), .bus_int_level(bus_int_level),
    .bus_size_rsvd(bus_size_rsvd), .bdm_class(bdm_class), .bdm_ext_dma(bdm_ext_dma));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // expected decode of a type and modifier pair
  function automatic logic [3:0] cls(input logic [4:0] tm, input logic background_debug_port);
    case (tm[4:3])
      2'h0: cls = (tm[2:0] == 3'h7) ? 4'h6 : (tm[2:0] == 3'h6) ? 4'hf : {1'b0, tm[2:0]};
      2'h1: cls = background_debug_port ? 4'ha : 4'hf;
      2'h2: cls = (tm[2:0] == 3'h5) ? 4'h7 : 4'hf;
      default: cls = (tm[2:0] == 3'h0) ? 4'h8 : 4'h9;
    endcase
  endfunction
  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    @(negedge core_clk);
    dbg_idx = idx;
    dbg_wdata = d;
    dbg_wr = 1'b1;
    @(negedge core_clk);
    dbg_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
    @(negedge core_clk);
    dbg_idx = idx;
    dbg_rd = 1'b1;
    @(negedge core_clk);
    dbg_rd = 1'b0;
    chk(dbg_rd_valid, 1);
    chk(dbg_rdata, exp);
  endtask
  // bus transfer and debug command together; back to back while go stays high
  task automatic xfer(input logic [7:0] a, input logic e0, input logic e1);
    @(negedge core_clk);
    go = 1'b1;
    bdm_cmd = 1'b1;
    attr = a;
    @(posedge core_clk);
    #1;
    chk(attr_hit_0, e0);
    chk(attr_hit_1, e1);
    chk(bus_class, cls(a[4:0], 1'b0));
    chk(bdm_class, cls(a[4:0], 1'b1));
    chk(bus_int_level, (a[4:3] == 2'h3) ? a[2:0] : 3'h0);
    chk(bus_size_rsvd, a[6:5] == 2'h3);
    chk(bdm_ext_dma, a[4:3] == 2'h1);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    rd(BAT_IDX_TRIG0, 32'h0000_0005);
    rd(BAT_IDX_TRIG1, 32'h0000_0005);
    rd(5'h07, BAT_RD_ZERO);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      wr(BAT_IDX_TRIG0, {16'hffff, tv[i]});
      wr(BAT_IDX_TRIG1, {16'h0000, tv[i]});
      xfer(av[i], ev[i], ev[i]);
      @(negedge core_clk);
      go = 1'b0;
      bdm_cmd = 1'b0;
    end
    use1 = 1'b0;
    xfer(8'h05, 1'b1, 1'b0);
    $display("test attribute compare done");
    wr(BAT_IDX_TRIG0, 32'hffff_ff00);
    wr(BAT_IDX_TRIG1, 32'h0000_ff00);
    use1 = 1'b1;
    rd(BAT_IDX_TRIG0, 32'h0000_ff00);
    for (int j = 0; j < 64; j++) begin
      xfer(j[7:0] ^ 8'h40, 1'b1, 1'b1);
    end
    @(negedge core_clk);
    go = 1'b0;
    bdm_cmd = 1'b0;
    $display("test decode sweep done");
    clk_en = 1'b0;
    wr(BAT_IDX_TRIG0, 32'h0000_1234);
    @(negedge core_clk);
    clk_en = 1'b1;
    rd(BAT_IDX_TRIG0, 32'h0000_ff00);
    $display("test clock enable done");
    finish_test;
  end
endmodule
